//--- sim/cer_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
// Port watch on the reporter; the low 12 address bits are the offset inside the page
module cer_top_checker (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [11:0] PADDR,
   input wire logic PSLVERR,
   input wire logic CTX_READY,
   input wire logic MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic [63:0] MEM_DATA,
   input wire logic MEM_SNOOP,
   input wire logic MEM_ACK,
   input wire logic IRQ
);
   // Offset decode shared by the page write checks
   wire [11:0] off = MEM_ADDR[11:0];
   wire ent = off >= 12'h0A0 && off <= 12'h0F8;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);
   // The far side may stall for any time, so the write must be held
   a_req_holds: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
      && $stable(MEM_DATA)) else $error("page write changed before ack");
   a_entry_slot: assert property (MEM_REQ |-> off == 12'h000 || off == 12'h11C
      || (ent && off[2:0] == 3'h0)) else $error("page write outside its slots");
   a_index_follows: assert property (MEM_REQ && MEM_ACK && ent |=> MEM_REQ
      && off == 12'h11C && MEM_DATA == (($past(off) - 12'h0A0) >> 3))
      else $error("last index write missing or wrong");
   a_index_range: assert property (MEM_REQ && off == 12'h11C |-> MEM_DATA < 64'd12)
      else $error("last index beyond buffer");
   a_isr_unforced: assert property (MEM_REQ && off == 12'h000 |-> MEM_DATA[9:6] == 4'h0
      && MEM_DATA[2:1] == 2'h0) else $error("forced bit in status write");
   a_snoop_on: assert property (MEM_REQ |-> MEM_SNOOP) else $error("write not snooped");
   a_slverr_map: assert property (PSEL && PENABLE && PADDR[1:0] == 2'h0
      |-> PSLVERR == (PADDR > 12'h024)) else $error("slave error decode wrong");
   a_slverr_access: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("slave error outside access");
   // Reset is checked on its own, so it cannot use the default disable
   a_reset_quiet: assert property (disable iff (1'b0) !NRST |=> !MEM_REQ && !IRQ
      && CTX_READY) else $error("outputs active in reset");
   c_entry: cover property (MEM_REQ && MEM_ACK && ent);
   c_unmapped: cover property (PSLVERR);
   c_irq: cover property ($rose(IRQ));
endmodule // cer_top_checker
bind cer_top cer_top_checker i_chk (.CLK_SYS, .NRST, .PSEL, .PENABLE, .PADDR, .PSLVERR,
   .CTX_READY, .MEM_REQ, .MEM_ADDR, .MEM_DATA, .MEM_SNOOP, .MEM_ACK, .IRQ);
`default_nettype wire

//--- sim/tb_cer_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cer_defs.vh"
module tb_cer_top;
   logic CLK_SYS = 0, NRST = 0, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, err;
   logic PREADY, PSLVERR, CTX_READY, MEM_REQ, MEM_SNOOP, IRQ, MEM_ACK = 0, CTX_SWITCH = 0;
   logic PAGE_FAULT = 0;
   logic [3:0] evt = 0, ptr;
   logic [11:0] PADDR = 0;
   logic [15:0] CTX_REASON = 0, ERR_STATUS = 0;
   logic [31:0] PWDATA = 0, PRDATA, MEM_ADDR, rd, page, x = 32'd56;
   logic [63:0] CTX_STATUS = 0, MEM_DATA, isr_wr, s;
   logic [95:0] got[$], exp_q[$];
   logic [11:0] ra[5] = '{12'h004, 12'h008, 12'h010, 12'h018, 12'h028};
   logic [31:0] re[5] = '{32'h3FF, 32'h3FF, 32'hFFFF, 32'h0, 32'h0};
   logic [31:0] eb[4] = '{32'h001, 32'h010, 32'h020, 32'h000};
   int fails = 0, tests_run = 0, n;
   always #4 CLK_SYS = ~CLK_SYS;
   cer_top i_dut (.CLK_SYS, .NRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .CTX_SWITCH, .CTX_REASON, .CTX_STATUS, .CTX_READY,
      .USER_EVT(evt[0]), .FLUSH_EVT(evt[1]), .L3_PARITY_EVT(evt[2]),
      .MEDIA_OVERRUN_EVT(evt[3]), .PAGE_FAULT, .ERR_STATUS, .MEM_REQ, .MEM_ADDR,
      .MEM_DATA, .MEM_SNOOP, .MEM_ACK, .IRQ);
   function automatic logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function automatic logic [31:0] ent(input logic [3:0] p);
      return (32'h28 + 2 * p) * 4;
   endfunction
   task automatic chk(input logic [95:0] g, e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One APB cycle; ends at the edge where pready was seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      @(posedge CLK_SYS);
      while (PREADY !== 1'b1) @(posedge CLK_SYS);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Far side of the page writes: random stalls, log of accepted writes
   always @(posedge CLK_SYS) begin
      if (MEM_REQ && MEM_ACK && MEM_ADDR[11:0] == 12'h000) isr_wr <= MEM_DATA;
      else if (MEM_REQ && MEM_ACK) got.push_back({MEM_ADDR, MEM_DATA});
      MEM_ACK <= rnd() > 32'h5FFF_FFFF;
   end
   // Whole run is a few hundred cycles
   initial begin
      #400000;
      fails++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge CLK_SYS);
      NRST <= 1'b1;
      foreach (ra[i]) begin
         apb(0, ra[i], 0);
         chk({err, rd}, {ra[i] == 12'h028, re[i]});
      end
      $display("reset values done");
      // Each source: sticky bit, level output, mask, write one to clear
      apb(1, `CER_OFF_IMR, 0);
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK_SYS);
         evt <= 4'h1 << i;
         @(posedge CLK_SYS);
         evt <= 4'h0;
         apb(0, `CER_OFF_ISR, 0);
         chk(rd, eb[i]);
         @(negedge CLK_SYS);
         chk(IRQ, eb[i] != 0);
         apb(1, `CER_OFF_IMR, eb[i]);
         @(negedge CLK_SYS);
         chk(IRQ, 1'b0);
         apb(1, `CER_OFF_ISR, 32'h3FF);
         apb(1, `CER_OFF_IMR, 0);
         apb(0, `CER_OFF_ISR, 0);
         chk(rd, 0);
      end
      $display("events done");
      // Fault level passes through; repair mode overrides the mask
      apb(1, `CER_OFF_IMR, 32'h3FF);
      PAGE_FAULT <= 1'b1;
      apb(0, `CER_OFF_ISR, 0);
      chk({IRQ, rd}, 33'h080);
      apb(1, `CER_OFF_CTRL, 32'h1);
      @(negedge CLK_SYS);
      chk(IRQ, 1'b1);
      @(posedge CLK_SYS);
      PAGE_FAULT <= 1'b0;
      apb(0, `CER_OFF_ISR, 0);
      chk({IRQ, rd}, 33'h0);
      apb(1, `CER_OFF_CTRL, 0);
      $display("page fault done");
      // Errors: status, mask, identity and the master error bit
      apb(1, `CER_OFF_EMR, 32'hFFFE);
      rd = rnd();
      ERR_STATUS <= rd[15:0] | 16'h0003;
      apb(0, `CER_OFF_ESR, 0);
      chk(rd, ERR_STATUS);
      apb(0, `CER_OFF_EIR, 0);
      chk(rd, 32'h1);
      apb(0, `CER_OFF_ISR, 0);
      chk(rd, 32'h8);
      ERR_STATUS <= 16'h0;
      apb(1, `CER_OFF_EIR, 32'hFFFE);
      apb(0, `CER_OFF_EIR, 0);
      chk(rd, 32'h1);
      apb(1, `CER_OFF_EIR, 32'h1);
      apb(0, `CER_OFF_ISR, 0);
      chk(rd, 0);
      $display("errors done");
      // Clock enable low freezes state and drops writes and events
      @(posedge CLK_SYS);
      CE <= 1'b0;
      evt <= 4'h1;
      apb(1, `CER_OFF_IMR, 32'h155);
      evt <= 4'h0;
      CE <= 1'b1;
      apb(0, `CER_OFF_IMR, 0);
      chk(rd, 32'h3FF);
      apb(0, `CER_OFF_ISR, 0);
      chk(rd, 32'h0);
      $display("clock enable done");
      // Status write carries unmasked bits but never the fault bit
      apb(1, `CER_OFF_STW_MASK, 0);
      @(posedge CLK_SYS);
      PAGE_FAULT <= 1'b1;
      evt <= 4'h1;
      @(posedge CLK_SYS);
      evt <= 4'h0;
      for (n = 0; n < 200 && isr_wr !== 64'h1; n++) @(posedge CLK_SYS);
      chk(isr_wr, 64'h1);
      PAGE_FAULT <= 1'b0;
      apb(1, `CER_OFF_ISR, 32'h3FF);
      $display("status write done");
      // Sixteen switches: masked reasons dropped, buffer wraps past twelve
      rd = rnd();
      page = rd & 32'hFFFF_F000;
      apb(1, `CER_OFF_PAGE_ADDR, rd);
      apb(1, `CER_OFF_CTX_MASK, 32'h1);
      apb(1, `CER_OFF_STW_MASK, 32'h3FF);
      got.delete();
      ptr = 0;
      for (int i = 0; i < 16; i++) begin
         @(negedge CLK_SYS);
         for (n = 0; n < 200 && CTX_READY !== 1'b1; n++) @(negedge CLK_SYS);
         @(posedge CLK_SYS);
         s = {rnd(), rnd()};
         CTX_REASON <= s[15:0];
         CTX_STATUS <= s;
         CTX_SWITCH <= 1'b1;
         if (!s[0]) begin
            exp_q.push_back({page + ent(ptr), s});
            exp_q.push_back({page + 32'h11C, 60'h0, ptr});
            ptr = (ptr == 4'd11) ? 4'd0 : ptr + 4'd1;
         end
         @(posedge CLK_SYS);
         CTX_SWITCH <= 1'b0;
      end
      for (n = 0; n < 400 && got.size() < exp_q.size(); n++) @(posedge CLK_SYS);
      chk(got.size(), exp_q.size());
      foreach (exp_q[i]) chk(got[i], exp_q[i]);
      apb(0, `CER_OFF_ISR, 0);
      chk(rd[8], 1'b1);
      apb(0, `CER_OFF_LAST_IDX, 0);
      chk(rd, (ptr + 32'd11) % 12);
      $display("context switches done");
      finish_test();
   end
endmodule // tb_cer_top
`default_nettype wire

//--- verilog/cer_defs.vh
`ifndef CER_DEFS_VH
`define CER_DEFS_VH

// Register byte offsets on the APB
`define CER_OFF_ISR 12'h000
`define CER_OFF_IMR 12'h004
`define CER_OFF_STW_MASK 12'h008
`define CER_OFF_EIR 12'h00C
`define CER_OFF_EMR 12'h010
`define CER_OFF_ESR 12'h014
`define CER_OFF_CTX_MASK 12'h018
`define CER_OFF_PAGE_ADDR 12'h01C
`define CER_OFF_CTRL 12'h020
`define CER_OFF_LAST_IDX 12'h024

// Interrupt vector bit positions, common to every interrupt control register
`define CER_BIT_USER 0
`define CER_BIT_MERR 3
`define CER_BIT_FLUSH 4
`define CER_BIT_L3PAR 5
`define CER_BIT_MEDIA 6
`define CER_BIT_PFAULT 7
`define CER_BIT_CTXSW 8
`define CER_IRQ_W 10
// Implemented interrupt bits (reserved 1, 2, 9 read zero)
`define CER_ISR_IMPL 10'h1F9
// Sticky, write-one-to-clear interrupt bits
`define CER_ISR_STICKY 10'h171
// Bits that can never be unmasked for the status write
`define CER_STW_FORCED 10'h1C0

// Reset values
`define CER_RST_IMR 10'h3FF
`define CER_RST_STW_MASK 10'h3FF
`define CER_RST_EMR 16'hFFFF
`define CER_RST_CTX_MASK 16'h0000

// Control register fields
`define CER_CTRL_REPAIR 0

// Status page layout, dword offsets
`define CER_DW_ISR 8'h00
`define CER_DW_CSB 8'h28
`define CER_DW_LAST 8'h47
`define CER_CSB_ENTRIES 12
// Status page is a naturally aligned 4KB page
`define CER_PAGE_BITS 12

`endif

//--- verilog/cer_stw.v
`timescale 1ns/100ps
`default_nettype none
`include "cer_defs.vh"

// Status page write engine: interrupt vector, status entries, last index
module cer_stw #(
   parameter ENTRIES = `CER_CSB_ENTRIES
) (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire [31:0] page_base,
   input wire isr_req,
   input wire [`CER_IRQ_W-1:0] isr_val,
   input wire ctx_req,
   input wire [63:0] ctx_val,
   output wire isr_take,
   output wire ctx_take,
   output wire [3:0] last_idx,
   output reg mem_req_r,
   output reg [31:0] mem_addr_r,
   output reg [63:0] mem_data_r,
   output wire mem_snoop,
   input wire mem_ack
);

   localparam S_IDLE = 2'd0;
   localparam S_BUSY = 2'd1;
   localparam S_IDX = 2'd2;

   reg [1:0] state_r;
   reg [3:0] wr_ptr_r;
   reg [3:0] last_r;

   // Byte address of a dword inside the status page
   function [31:0] dw_addr;
      input [31:0] base;
      input [7:0] dw;
      begin
         dw_addr = {base[31:`CER_PAGE_BITS], 2'b00, dw, 2'b00};
      end
   endfunction

   // Status entries come first so a burst of switches drains steadily
   assign ctx_take = (state_r == S_IDLE) && ctx_req;
   assign isr_take = (state_r == S_IDLE) && !ctx_req && isr_req;
   assign last_idx = last_r;
   assign mem_snoop = 1'b1; // R15

   always @(posedge clk) begin
      if (!nrst) begin
         state_r <= S_IDLE;
         wr_ptr_r <= 4'h0;
         last_r <= 4'h0;
         mem_req_r <= 1'b0;
         mem_addr_r <= 32'h0000_0000;
         mem_data_r <= 64'h0000_0000_0000_0000;
      end else if (ce) begin
         case (state_r)
            S_IDLE: begin
               if (ctx_take) begin
                  // Entry is a qword, two dwords per slot
                  mem_addr_r <= dw_addr(page_base, `CER_DW_CSB + {3'b000, wr_ptr_r, 1'b0}); // R16
                  mem_data_r <= ctx_val;
                  mem_req_r <= 1'b1;
                  last_r <= wr_ptr_r; // R17
                  wr_ptr_r <= (wr_ptr_r == ENTRIES - 1) ? 4'h0 : wr_ptr_r + 4'h1; // R16
                  state_r <= S_IDX;
               end else if (isr_take) begin
                  mem_addr_r <= dw_addr(page_base, `CER_DW_ISR); // R10
                  mem_data_r <= {{(64-`CER_IRQ_W){1'b0}}, isr_val};
                  mem_req_r <= 1'b1;
                  state_r <= S_BUSY;
               end
            end
            S_IDX: begin
               // Entry done, now name it in the last written index
               if (mem_ack) begin
                  mem_addr_r <= dw_addr(page_base, `CER_DW_LAST); // R17
                  mem_data_r <= {60'h0, last_r};
                  state_r <= S_BUSY;
               end
            end
            S_BUSY: begin
               if (mem_ack) begin
                  mem_req_r <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            default: begin
               mem_req_r <= 1'b0;
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule // cer_stw

`default_nettype wire

//--- verilog/cer_top.v
`timescale 1ns/100ps
`default_nettype none
`include "cer_defs.vh"

// Notes on behaviour
// R1: Every context switch with an unmasked reason is reported with its context status as a status entry.
// R2: A reason masked in the context mask gives neither interrupt nor entry.
// R3: All interrupt registers share one bit layout.
// R4: Bit 8 marks a context switch and is never status written.
// R5: Bit 7 follows a pending page table fault, never status written.
// R6: In fault repair mode the page fault interrupt ignores its mask.
// R7: Bit 6 flags media counter overrun on media engines, never status written.
// R8: Bit 5 flags L3 parity, only on the render engine.
// R9: Bit 3 follows errors; status written when unmasked.
// R10: On any interrupt status change, unmasked bits go to the status page.
// R11: Error mask selects which error status bits reach error identity.
// R12: Any error identity bit sets the interrupt error bit.
// R13: Error identity bits clear by writing one, unrecoverable ones excepted.
// R14: Software puts the status page on a 4KB boundary and programs it.
// R15: Status page writes are cacheable and snooped.
// R16: Status entries fill a wrapping buffer from dword 28h upward.
// R17: Each entry updates the 4-bit last index at dword 47h.
// R18: Interrupt output is high while an unmasked status bit is set.
module cer_top #(
   parameter IS_RENDER = 1'b1,
   parameter IS_MEDIA = 1'b0,
   parameter ERR_W = 16,
   parameter REASON_W = 16,
   parameter [15:0] UNRECOVERABLE = 16'h0000
) (
   input wire CLK_SYS,
   input wire NRST,
   input wire CE,
   // APB slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   // Engine events
   input wire CTX_SWITCH,
   input wire [REASON_W-1:0] CTX_REASON,
   input wire [63:0] CTX_STATUS,
   output wire CTX_READY,
   input wire USER_EVT,
   input wire FLUSH_EVT,
   input wire L3_PARITY_EVT,
   input wire MEDIA_OVERRUN_EVT,
   input wire PAGE_FAULT,
   input wire [ERR_W-1:0] ERR_STATUS,
   // Status page writes and interrupt output
   output wire MEM_REQ,
   output wire [31:0] MEM_ADDR,
   output wire [63:0] MEM_DATA,
   output wire MEM_SNOOP,
   input wire MEM_ACK,
   output wire IRQ
);

   localparam W = `CER_IRQ_W;

   // Configuration and pending state
   reg [W-1:0] isr_sticky_r;
   reg [W-1:0] imr_r;
   reg [W-1:0] stw_mask_r;
   reg [ERR_W-1:0] eir_r;
   reg [ERR_W-1:0] emr_r;
   reg [REASON_W-1:0] ctx_mask_r;
   reg [31:0] page_addr_r;
   reg repair_r;
   reg [W-1:0] isr_prev_r;
   reg isr_pend_r;
   reg ctx_pend_r;
   reg [63:0] ctx_data_r;

   // Interrupt vector paths
   wire [W-1:0] interrupt_status_reg;
   wire [W-1:0] isr_set;
   wire [W-1:0] isr_clr;
   wire [W-1:0] stw_eff;
   wire [W-1:0] irq_vec;
   wire [ERR_W-1:0] eir_clr;
   wire [3:0] last_idx;
   wire isr_take;
   wire ctx_take;
   wire ctx_report;
   wire wr_en;
   wire rd_en;
   wire acc;
   reg mapped;

   // Address decode shared by read and write paths
   function is_mapped;
      input [11:0] a;
      begin
         case (a)
            `CER_OFF_ISR, `CER_OFF_IMR, `CER_OFF_STW_MASK, `CER_OFF_EIR,
            `CER_OFF_EMR, `CER_OFF_ESR, `CER_OFF_CTX_MASK, `CER_OFF_PAGE_ADDR,
            `CER_OFF_CTRL, `CER_OFF_LAST_IDX: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // Write strobe for one register offset, used by the clear paths
   function wr_hit;
      input [11:0] a;
      input [11:0] off;
      input en;
      begin
         wr_hit = en && (a == off);
      end
   endfunction

   // Zero wait states: every access completes in its first access cycle
   // Reads sample in setup, so a bit set during the access shows on the next read
   assign acc = PSEL && PENABLE;
   assign PREADY = 1'b1;
   assign PSLVERR = acc && !mapped;
   assign wr_en = acc && PWRITE && mapped && CE;
   assign rd_en = PSEL && !PENABLE && !PWRITE;

   always @* begin
      mapped = is_mapped(PADDR);
   end

   // A switch whose reason is masked is dropped whole
   assign ctx_report = CTX_SWITCH && CTX_READY && ((CTX_REASON & ctx_mask_r) == {REASON_W{1'b0}}); // R2
   // One pending entry; the engine stalls until it is handed off
   assign CTX_READY = !ctx_pend_r;

   // Event sources placed by the common vector layout
   // Reserved positions 1, 2 and 9 stay zero; bits 3 and 7 are levels, not stored
   assign isr_set[`CER_BIT_USER] = USER_EVT; // R3
   assign isr_set[2:1] = 2'b00;
   assign isr_set[`CER_BIT_MERR] = 1'b0;
   assign isr_set[`CER_BIT_FLUSH] = FLUSH_EVT;
   assign isr_set[`CER_BIT_L3PAR] = L3_PARITY_EVT && IS_RENDER; // R8
   assign isr_set[`CER_BIT_MEDIA] = MEDIA_OVERRUN_EVT && IS_MEDIA; // R7
   assign isr_set[`CER_BIT_PFAULT] = 1'b0;
   assign isr_set[`CER_BIT_CTXSW] = ctx_report; // R4
   assign isr_set[9] = 1'b0;

   assign isr_clr = wr_hit(PADDR, `CER_OFF_ISR, wr_en) ? PWDATA[W-1:0] & `CER_ISR_STICKY :
      {W{1'b0}};

   // Level bits follow their source, the rest are sticky
   assign interrupt_status_reg = (isr_sticky_r & `CER_ISR_STICKY)
      | ({{(W-1){1'b0}}, (|eir_r)} << `CER_BIT_MERR) // R9 R12
      | ({{(W-1){1'b0}}, PAGE_FAULT} << `CER_BIT_PFAULT); // R5

   // Unmaskable positions stay masked for the status write
   assign stw_eff = stw_mask_r | `CER_STW_FORCED; // R4 R5 R7

   // Interrupt output; page fault bypasses its mask in repair mode
   assign irq_vec = interrupt_status_reg & ~imr_r; // R18
   assign IRQ = (|irq_vec) || (repair_r && interrupt_status_reg[`CER_BIT_PFAULT]); // R6

   // Unrecoverable identity bits ignore software clears
   assign eir_clr = wr_hit(PADDR, `CER_OFF_EIR, wr_en) ?
      PWDATA[ERR_W-1:0] & ~UNRECOVERABLE[ERR_W-1:0] : {ERR_W{1'b0}}; // R13

   // Sticky interrupt bits: set wins over a simultaneous clear
   // Level bits 3 and 7 are never held here, they follow their sources
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         isr_sticky_r <= {W{1'b0}};
      end else if (CE) begin
         isr_sticky_r <= ((isr_sticky_r & ~isr_clr) | isr_set) & `CER_ISR_STICKY;
      end
   end

   // Error identity: masked status never propagates, set beats clear
   // A clear and a new error in one cycle leave the bit set, so nothing is lost
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         eir_r <= {ERR_W{1'b0}};
      end else if (CE) begin
         eir_r <= (eir_r & ~eir_clr) | (ERR_STATUS & ~emr_r); // R11 R13
      end
   end

   // Register map, one aligned word each:
   //   00 interrupt status, level bits read through, sticky bits write one to clear
   //   04 interrupt mask, a one masks the bit from the output
   //   08 status write mask, bits 6 to 8 always read as masked
   //   0C error identity, write one to clear
   //   10 error mask, a one keeps the error out of the identity
   //   14 error status, read only view of the error inputs
   //   18 context reason mask, a one drops switches with that reason
   //   1C status page base, low twelve bits read zero
   //   20 control, bit 0 enables fault repair mode
   //   24 last written status entry index
   // Software-written configuration
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         imr_r <= `CER_RST_IMR;
         stw_mask_r <= `CER_RST_STW_MASK;
         emr_r <= `CER_RST_EMR;
         ctx_mask_r <= `CER_RST_CTX_MASK;
         page_addr_r <= 32'h0000_0000;
         repair_r <= 1'b0;
      end else if (wr_en) begin
         case (PADDR)
            `CER_OFF_IMR: imr_r <= PWDATA[W-1:0];
            `CER_OFF_STW_MASK: stw_mask_r <= PWDATA[W-1:0];
            `CER_OFF_EMR: emr_r <= PWDATA[ERR_W-1:0];
            `CER_OFF_CTX_MASK: ctx_mask_r <= PWDATA[REASON_W-1:0];
            // Low bits dropped: the page sits on a 4KB boundary
            `CER_OFF_PAGE_ADDR: page_addr_r <= {PWDATA[31:`CER_PAGE_BITS], 12'h000}; // R14
            `CER_OFF_CTRL: repair_r <= PWDATA[`CER_CTRL_REPAIR];
            default: repair_r <= repair_r;
         endcase
      end
   end

   // Read data captured in the setup cycle, stable through the access
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         PRDATA <= 32'h0000_0000;
      end else if (CE && rd_en) begin
         case (PADDR)
            `CER_OFF_ISR: PRDATA <= {{(32-W){1'b0}}, interrupt_status_reg};
            `CER_OFF_IMR: PRDATA <= {{(32-W){1'b0}}, imr_r};
            `CER_OFF_STW_MASK: PRDATA <= {{(32-W){1'b0}}, stw_eff};
            `CER_OFF_EIR: PRDATA <= {{(32-ERR_W){1'b0}}, eir_r};
            `CER_OFF_EMR: PRDATA <= {{(32-ERR_W){1'b0}}, emr_r};
            `CER_OFF_ESR: PRDATA <= {{(32-ERR_W){1'b0}}, ERR_STATUS};
            `CER_OFF_CTX_MASK: PRDATA <= {{(32-REASON_W){1'b0}}, ctx_mask_r};
            `CER_OFF_PAGE_ADDR: PRDATA <= page_addr_r;
            `CER_OFF_CTRL: PRDATA <= {31'h0000_0000, repair_r};
            `CER_OFF_LAST_IDX: PRDATA <= {28'h000_0000, last_idx};
            default: PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // Change watch on the vector; latest value is written when the engine frees
   // Limitation: changes that come and go while a write waits are merged into
   // one write of the newest value, so software sees no intermediate states
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         isr_prev_r <= {W{1'b0}};
         isr_pend_r <= 1'b0;
      end else if (CE) begin
         isr_prev_r <= interrupt_status_reg;
         if (interrupt_status_reg != isr_prev_r) begin
            isr_pend_r <= 1'b1; // R10
         end else if (isr_take) begin
            isr_pend_r <= 1'b0;
         end
      end
   end

   // Pending status entry holding the switch context status
   // The engine holds off further switches until the write engine takes this one
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         ctx_pend_r <= 1'b0;
         ctx_data_r <= 64'h0000_0000_0000_0000;
      end else if (CE) begin
         if (ctx_report) begin
            ctx_pend_r <= 1'b1; // R1
            ctx_data_r <= CTX_STATUS;
         end else if (ctx_take) begin
            ctx_pend_r <= 1'b0;
         end
      end
   end

   cer_stw #(
      .ENTRIES(`CER_CSB_ENTRIES)
   ) u_stw (
      .clk(CLK_SYS),
      .nrst(NRST),
      .ce(CE),
      .page_base(page_addr_r),
      .isr_req(isr_pend_r),
      .isr_val(interrupt_status_reg & ~stw_eff), // R10
      .ctx_req(ctx_pend_r),
      .ctx_val(ctx_data_r),
      .isr_take(isr_take),
      .ctx_take(ctx_take),
      .last_idx(last_idx),
      .mem_req_r(MEM_REQ),
      .mem_addr_r(MEM_ADDR),
      .mem_data_r(MEM_DATA),
      .mem_snoop(MEM_SNOOP),
      .mem_ack(MEM_ACK)
   );

endmodule // cer_top

`default_nettype wire
